// ===== logic/dcpu_top.sv
// Overview of operation
// R1: every accepted 32-bit word is folded once into the running crc32 signature, unless a seed write lands in the same cycle.
// R2: scan mode words come from the dma source channel, which delivers them.
// R3: transfer mode forwards each checked word to the dma destination channel.
// R4: hardware compares signature to expected value and flags any difference.
// R5: a mismatch raises an interrupt if its intEn bit is set and, if trigEn is set, a trigger pulse.
// R6: fill mode writes a 1D or 2D block of a constant value.
// R7: unit works on 32-bit words, on the single peripheral system clock.
// R8: polynomial and expected value are writable; the signature is readable.
`timescale 1ns/1ps
`include "dcpu_map.svh"
module dcpu_top
  import dcpu_pkg::*;
(
  input  wire logic                   clk,
  input  wire logic                   sys_rst,
  input  wire logic [`DCPU_ADDR_W-1:0] paddr,
  input  wire logic                   psel,
  input  wire logic                   penable,
  input  wire logic                   pwrite,
  input  wire logic [31:0]            pwdata,
  output logic      [31:0]            prdata,
  output logic                        pready,
  output logic                        pslverr,
  input  wire logic                   srcValid,
  input  wire logic [31:0]            srcData,
  output logic                        srcReady,
  output logic                        dstValid,
  output logic      [31:0]            dstData,
  output logic                        dstRowEnd,
  input  wire logic                   dstReady,
  output logic                        irq,
  output logic                        faultTrig
);
  // --------------------------------------------------------------------
  // state
  // --------------------------------------------------------------------
  logic [31:0]           ctrl_reg, poly_reg, expect_reg, sig_reg, sig_next;
  logic [31:0]           fillVal_reg, fillDim_reg, wcount_reg, wcount_next;
  logic [`DCPU_ST_W-1:0] stat_reg, stat_next, intEn_reg;
  dcpu_fill_t            fill_reg, fill_next;
  logic [15:0]           xCnt_reg, yCnt_reg, xCnt_next, yCnt_next;
  logic                  ready_reg, ready_next, pready_reg, pslverr_reg;
  logic [31:0]           prdata_reg, dstData_reg, dstData_next;
  logic                  dstValid_reg, dstValid_next, rowEnd_reg, rowEnd_next;
  logic                  irq_reg, trig_reg, trig_next;

  // --------------------------------------------------------------------
  // apb decode
  // --------------------------------------------------------------------
  // access phase runs two cycles: pready rises the cycle after penable
  wire apbFirst = psel & penable & ~pready_reg;
  wire apbDone  = psel & penable & pready_reg;
  wire wrEn     = apbDone & pwrite;
  wire hitCtrl  = paddr == `DCPU_OFS_CTRL;
  wire hitPoly  = paddr == `DCPU_OFS_POLY;
  wire hitSeed  = paddr == `DCPU_OFS_SEED;
  wire hitExp   = paddr == `DCPU_OFS_EXPECT;
  wire hitRes   = paddr == `DCPU_OFS_RESULT;
  wire hitFVal  = paddr == `DCPU_OFS_FILLVAL;
  wire hitFDim  = paddr == `DCPU_OFS_FILLDIM;
  wire hitStat  = paddr == `DCPU_OFS_STATUS;
  wire hitIEn   = paddr == `DCPU_OFS_INTEN;
  wire hitIClr  = paddr == `DCPU_OFS_INTCLR;
  wire hitWcnt  = paddr == `DCPU_OFS_WCOUNT;
  wire hitCmd   = paddr == `DCPU_OFS_CMD;
  wire mapped   = hitCtrl | hitPoly | hitSeed | hitExp | hitRes | hitFVal
                | hitFDim | hitStat | hitIEn | hitIClr | hitWcnt | hitCmd;
  wire seedWr   = wrEn & hitSeed;
  wire cmpWr    = wrEn & hitCmd & pwdata[`DCPU_CMD_CMP];
  wire fillWr   = wrEn & hitCmd & pwdata[`DCPU_CMD_FILL];

  // read mux; write-only registers and seed read back as zero
  wire [31:0] rdMux =
      hitCtrl ? ctrl_reg    : hitPoly ? poly_reg   :
      hitExp  ? expect_reg  : hitRes  ? sig_reg    :
      hitFVal ? fillVal_reg : hitFDim ? fillDim_reg :
      hitStat ? {{(32-`DCPU_ST_W){1'b0}}, stat_reg} :
      hitIEn  ? {{(32-`DCPU_ST_W){1'b0}}, intEn_reg} :
      hitWcnt ? wcount_reg  : 32'h00000000;

  // --------------------------------------------------------------------
  // control fields
  // --------------------------------------------------------------------
  wire        enable = ctrl_reg[`DCPU_CTRL_EN];
  wire        trigEn = ctrl_reg[`DCPU_CTRL_TRIGEN];
  dcpu_mode_t mode;
  assign mode = dcpu_mode_t'(ctrl_reg[`DCPU_CTRL_MODE_HI:`DCPU_CTRL_MODE_LO]);
  wire modeXfer = mode == DCPU_XFER;
  wire modeVer  = mode == DCPU_VERIFY;
  wire modeFill = mode == DCPU_FILL;

  // --------------------------------------------------------------------
  // stream handshakes
  // --------------------------------------------------------------------
  // R7: word per clock in scan and verify; transfer takes at most one word every two clocks
  wire accept  = srcValid & ready_reg;
  wire dstFree = ~dstValid_reg | dstReady;
  // R6: fill pacing
  wire fillPush = (fill_reg == DCPU_FRUN) & dstFree;
  wire [15:0] xLen = fillDim_reg[15:0];
  wire [15:0] yLen = fillDim_reg[31:16];
  // a zero length behaves as one, so a fill always ends
  wire rowLast  = ({1'b0, xCnt_reg} + 17'h00001) >= {1'b0, xLen};
  wire blkLast  = rowLast & (({1'b0, yCnt_reg} + 17'h00001) >= {1'b0, yLen});

  // R2: source paced
  // ready only where a word can be taken; transfer waits for an empty slot
  assign ready_next = enable & ~modeFill & (~modeXfer | ~dstValid_next);

  // R3: forward to destination
  assign dstValid_next = (accept & modeXfer) | fillPush ? 1'b1
                       : (dstReady ? 1'b0 : dstValid_reg);
  assign dstData_next  = fillPush ? fillVal_reg
                       : (accept & modeXfer) ? srcData : dstData_reg;
  assign rowEnd_next   = fillPush ? rowLast
                       : (accept & modeXfer) ? 1'b0 : rowEnd_reg;

  // --------------------------------------------------------------------
  // fill sequencer
  // --------------------------------------------------------------------
  // R6: 1D or 2D walk
  always_comb begin
    fill_next = fill_reg;
    xCnt_next = xCnt_reg;
    yCnt_next = yCnt_reg;
    unique case (fill_reg)
      DCPU_FIDLE: begin
        if (fillWr & enable & modeFill) begin
          fill_next = DCPU_FRUN;
          xCnt_next = 16'h0000;
          yCnt_next = 16'h0000;
        end
      end
      DCPU_FRUN: begin
        if (~enable) begin
          fill_next = DCPU_FIDLE;
        end else if (fillPush) begin
          xCnt_next = rowLast ? 16'h0000 : xCnt_reg + 16'h0001;
          yCnt_next = rowLast ? yCnt_reg + 16'h0001 : yCnt_reg;
          if (blkLast) begin
            fill_next = DCPU_FIDLE;
          end
        end
      end
    endcase
  end

  // --------------------------------------------------------------------
  // signature path
  // --------------------------------------------------------------------
  wire        fold    = accept | fillPush;
  wire [31:0] foldSel = fillPush ? fillVal_reg : srcData;
  logic [31:0] bitRev;
  // bit mirror, one wire per bit
  for (genvar i = 0; i < 32; i++) begin : g_mirror
    assign bitRev[i] = foldSel[31-i];
  end
  wire [31:0] bitSel  = ctrl_reg[`DCPU_CTRL_BITMIR] ? bitRev : foldSel;
  wire [31:0] crcWord = ctrl_reg[`DCPU_CTRL_BYTEMIR]
                      ? {bitSel[7:0], bitSel[15:8], bitSel[23:16], bitSel[31:24]}
                      : bitSel;
  logic [31:0] crcStep;

  dcpu_crc_engine i_dcpu_crc_engine (
    .crcIn  (sig_reg),
    .dataIn (crcWord),
    .poly   (poly_reg),
    .crcOut (crcStep)
  );

  // R1: one fold per word
  assign sig_next    = seedWr ? pwdata : (fold ? crcStep : sig_reg);
  assign wcount_next = seedWr ? 32'h00000000 : (fold ? wcount_reg + 32'h00000001 : wcount_reg);

  // --------------------------------------------------------------------
  // events
  // --------------------------------------------------------------------
  // R4: hardware compare
  wire sigMis  = cmpWr & (sig_reg != expect_reg);
  wire dataMis = accept & modeVer & (srcData != fillVal_reg);
  wire fillEnd = fillPush & blkLast;
  wire [`DCPU_ST_W-1:0] stSet = {cmpWr, fillEnd, dataMis, sigMis};
  wire [`DCPU_ST_W-1:0] stClr = (wrEn & hitIClr) ? pwdata[`DCPU_ST_W-1:0] : '0;
  // set beats a clear landing in the same cycle
  assign stat_next = (stat_reg & ~stClr) | stSet;
  // R5: fault trigger
  assign trig_next = (sigMis | dataMis) & trigEn;

  // --------------------------------------------------------------------
  // registers
  // --------------------------------------------------------------------
  // R8: software storage
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      ctrl_reg    <= `DCPU_CTRL_RST;
      poly_reg    <= `DCPU_POLY_RST;
      expect_reg  <= `DCPU_ZERO_RST;
      fillVal_reg <= `DCPU_ZERO_RST;
      fillDim_reg <= `DCPU_ZERO_RST;
      intEn_reg   <= '0;
    end else if (wrEn) begin
      if (hitCtrl) ctrl_reg    <= pwdata;
      if (hitPoly) poly_reg    <= pwdata;
      if (hitExp)  expect_reg  <= pwdata;
      if (hitFVal) fillVal_reg <= pwdata;
      if (hitFDim) fillDim_reg <= pwdata;
      if (hitIEn)  intEn_reg   <= pwdata[`DCPU_ST_W-1:0];
    end
  end

  // apb answer is registered so every bus output comes from a flop
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      pready_reg  <= 1'b0;
      pslverr_reg <= 1'b0;
      prdata_reg  <= `DCPU_ZERO_RST;
    end else begin
      pready_reg  <= apbFirst;
      pslverr_reg <= apbFirst & ~mapped;
      prdata_reg  <= apbFirst & ~pwrite ? rdMux : 32'h00000000;
    end
  end

  // datapath and status flops
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      sig_reg      <= `DCPU_SEED_RST;
      wcount_reg   <= `DCPU_ZERO_RST;
      stat_reg     <= '0;
      fill_reg     <= DCPU_FIDLE;
      xCnt_reg     <= 16'h0000;
      yCnt_reg     <= 16'h0000;
      ready_reg    <= 1'b0;
      dstValid_reg <= 1'b0;
      dstData_reg  <= `DCPU_ZERO_RST;
      rowEnd_reg   <= 1'b0;
      irq_reg      <= 1'b0;
      trig_reg     <= 1'b0;
    end else begin
      sig_reg      <= sig_next;
      wcount_reg   <= wcount_next;
      stat_reg     <= stat_next;
      fill_reg     <= fill_next;
      xCnt_reg     <= xCnt_next;
      yCnt_reg     <= yCnt_next;
      ready_reg    <= ready_next;
      dstValid_reg <= dstValid_next;
      dstData_reg  <= dstData_next;
      rowEnd_reg   <= rowEnd_next;
      // R5: level interrupt
      irq_reg      <= |(stat_reg & intEn_reg);
      trig_reg     <= trig_next;
    end
  end

  assign prdata    = prdata_reg;
  assign pready    = pready_reg;
  assign pslverr   = pslverr_reg;
  assign srcReady  = ready_reg;
  assign dstValid  = dstValid_reg;
  assign dstData   = dstData_reg;
  assign dstRowEnd = rowEnd_reg;
  assign irq       = irq_reg;
  assign faultTrig = trig_reg;

  // --------------------------------------------------------------------
  // assertions
  // --------------------------------------------------------------------
  AST_SIG_HOLD: assert property ( // R1
    @(posedge clk) disable iff (sys_rst)
    !fold && !seedWr |=> $stable(sig_reg) && $stable(wcount_reg))
    else $error("signature moved without a word");

  AST_WORD_COUNT: assert property ( // R1
    @(posedge clk) disable iff (sys_rst)
    fold && !seedWr |=> wcount_reg == $past(wcount_reg) + 32'h00000001)
    else $error("word count did not step once");

  AST_SRC_READY: assert property ( // R2
    @(posedge clk) disable iff (sys_rst)
    ready_reg |-> $past(enable) && !$past(modeFill))
    else $error("source ready outside an active mode");

  AST_XFER_FWD: assert property ( // R3
    @(posedge clk) disable iff (sys_rst)
    accept && modeXfer |=> dstValid_reg && dstData_reg == $past(srcData))
    else $error("transfer word not forwarded");

  AST_DST_HOLD: assert property ( // R3
    @(posedge clk) disable iff (sys_rst)
    dstValid_reg && !dstReady |=> dstValid_reg && $stable(dstData_reg))
    else $error("destination word dropped under stall");

  AST_CMP_FLAG: assert property ( // R4
    @(posedge clk) disable iff (sys_rst)
    cmpWr && sig_reg != expect_reg |=> stat_reg[`DCPU_ST_SIGERR])
    else $error("mismatch not flagged");

  AST_IRQ_LEVEL: assert property ( // R5
    @(posedge clk) disable iff (sys_rst)
    sigMis && intEn_reg[`DCPU_ST_SIGERR] |-> ##2 irq_reg)
    else $error("interrupt missing after mismatch");

  AST_TRIG_PULSE: assert property ( // R5
    @(posedge clk) disable iff (sys_rst)
    faultTrig |-> $past(sigMis | dataMis) && $past(trigEn))
    else $error("trigger without a fault");

  AST_FILL_DATA: assert property ( // R6
    @(posedge clk) disable iff (sys_rst)
    fillPush |=> dstValid_reg && dstData_reg == $past(fillVal_reg))
    else $error("fill word wrong");

  AST_APB_READY: assert property ( // R7
    @(posedge clk) disable iff (sys_rst)
    apbFirst |=> pready_reg ##1 !pready_reg)
    else $error("apb answer not one cycle");

  AST_POLY_WRITE: assert property ( // R8
    @(posedge clk) disable iff (sys_rst)
    wrEn && hitPoly |=> poly_reg == $past(pwdata))
    else $error("polynomial write lost");

  AST_SEED_LOAD: assert property ( // R8
    @(posedge clk) disable iff (sys_rst)
    seedWr |=> sig_reg == $past(pwdata) && wcount_reg == 32'h00000000)
    else $error("seed write did not restart the signature");

  AST_DATA_FLAG: assert property ( // R4
    @(posedge clk) disable iff (sys_rst)
    dataMis |=> stat_reg[`DCPU_ST_DATAERR])
    else $error("verify mismatch not flagged");

  AST_FILL_DONE: assert property ( // R6
    @(posedge clk) disable iff (sys_rst)
    fillEnd |=> stat_reg[`DCPU_ST_FILLDONE] && fill_reg == DCPU_FIDLE)
    else $error("fill block did not finish");

  AST_IRQ_CLEAR: assert property ( // R5
    @(posedge clk) disable iff (sys_rst)
    (stat_reg & intEn_reg) == '0 |=> !irq_reg)
    else $error("interrupt high with no enabled status");
endmodule

// ===== logic/dcpu_map.svh
`ifndef DCPU_MAP_SVH
`define DCPU_MAP_SVH
// ----------------------------------------------------------------------
// register byte offsets on the apb slave
// ----------------------------------------------------------------------
`define DCPU_ADDR_W        12
`define DCPU_OFS_CTRL      12'h000
`define DCPU_OFS_POLY      12'h004
`define DCPU_OFS_SEED      12'h008
`define DCPU_OFS_EXPECT    12'h00c
`define DCPU_OFS_RESULT    12'h010
`define DCPU_OFS_FILLVAL   12'h014
`define DCPU_OFS_FILLDIM   12'h018
`define DCPU_OFS_STATUS    12'h01c
`define DCPU_OFS_INTEN     12'h020
`define DCPU_OFS_INTCLR    12'h024
`define DCPU_OFS_WCOUNT    12'h028
`define DCPU_OFS_CMD       12'h02c
// ----------------------------------------------------------------------
// field positions
// ----------------------------------------------------------------------
`define DCPU_CTRL_EN       0
`define DCPU_CTRL_MODE_LO  1
`define DCPU_CTRL_MODE_HI  2
`define DCPU_CTRL_BITMIR   3
`define DCPU_CTRL_BYTEMIR  4
`define DCPU_CTRL_TRIGEN   5
`define DCPU_CMD_CMP       0
`define DCPU_CMD_FILL      1
`define DCPU_ST_SIGERR     0
`define DCPU_ST_DATAERR    1
`define DCPU_ST_FILLDONE   2
`define DCPU_ST_CMPDONE    3
`define DCPU_ST_W          4
// ----------------------------------------------------------------------
// reset values
// ----------------------------------------------------------------------
`define DCPU_CTRL_RST      32'h00000000
`define DCPU_POLY_RST      32'h04c11db7
`define DCPU_SEED_RST      32'hffffffff
`define DCPU_ZERO_RST      32'h00000000
`endif

// ===== logic/dcpu_pkg.sv
package dcpu_pkg;
  // operating mode, held in the control register mode field
  typedef enum logic [1:0] {
    DCPU_SCAN,
    DCPU_XFER,
    DCPU_VERIFY,
    DCPU_FILL
  } dcpu_mode_t;
  // block fill sequencer
  typedef enum logic {
    DCPU_FIDLE,
    DCPU_FRUN
  } dcpu_fill_t;
endpackage

// ===== logic/dcpu_crc_engine.sv
`timescale 1ns/1ps
// ----------------------------------------------------------------------
// one-word crc32 step, msb first, any polynomial
// ----------------------------------------------------------------------
module dcpu_crc_engine
  import dcpu_pkg::*;
(
  input  wire logic [31:0] crcIn,
  input  wire logic [31:0] dataIn,
  input  wire logic [31:0] poly,
  output logic      [31:0] crcOut
);
  // whole word folded in one cycle; deep xor tree, fine at this clock rate
  always_comb begin
    logic [31:0] c;
    logic        fb;
    c  = crcIn;
    fb = 1'b0;
    for (int i = 31; i >= 0; i--) begin
      fb = c[31] ^ dataIn[i];
      c  = {c[30:0], 1'b0} ^ (fb ? poly : 32'h00000000);
    end
    crcOut = c;
  end
endmodule

// ===== tb/dcpu_dma_model.sv
`timescale 1ns/1ps
// ----------------------------------------------------------------------
// dma source and destination channel model
// ----------------------------------------------------------------------
module dcpu_dma_model (
  input  wire logic        clk,
  input  wire logic        stall,
  input  wire logic        srcReady,
  output logic             srcValid,
  output logic      [31:0] srcData,
  output logic             dstReady
);
  // idle at time zero
  initial begin
    srcValid = 1'b0;
    srcData  = 32'h00000000;
    dstReady = 1'b0;
  end
  // source delivers words
  // the word holds until taken; the idle bus then shows the inverse so stale data never matches
  task automatic send(input logic [31:0] w);
    @(posedge clk);
    srcValid <= 1'b1;
    srcData  <= w;
    do @(posedge clk); while (srcReady !== 1'b1);
    srcValid <= 1'b0;
    srcData  <= ~w;
  endtask
  // destination takes at once, or stalls at random to back-pressure the block
  always @(posedge clk) begin
    dstReady <= stall ? 1'($urandom()) : 1'b1;
  end
endmodule

// ===== tb/dcpu_top_bench.sv
`timescale 1ns/1ps
`include "dcpu_map.svh"
module dcpu_top_bench
  import dcpu_pkg::*;
;
  logic        clk, sys_rst, psel, penable, pwrite, pready, pslverr, stall;
  logic        srcValid, srcReady, dstValid, dstRowEnd, dstReady, irq, faultTrig;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, srcData, dstData, crc, w, poly, fv, mw;
  logic [31:0] dims[2];
  logic [32:0] expRd[$];
  logic [32:0] expDst[$];
  int          failures, cmp_count, trigCount, nx, ny;

  dcpu_top i_dcpu_top (.clk(clk), .sys_rst(sys_rst), .paddr(paddr), .psel(psel),
    .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .srcValid(srcValid), .srcData(srcData), .srcReady(srcReady),
    .dstValid(dstValid), .dstData(dstData), .dstRowEnd(dstRowEnd), .dstReady(dstReady),
    .irq(irq), .faultTrig(faultTrig));
  dcpu_dma_model i_dcpu_dma_model (.clk(clk), .stall(stall), .srcReady(srcReady),
    .srcValid(srcValid), .srcData(srcData), .dstReady(dstReady));

  // ----------------------------------------------------------------------
  // reference and bus helpers
  // ----------------------------------------------------------------------
  // msb-first word step, no reflection and no final xor
  function automatic logic [31:0] crcStep(input logic [31:0] c, d, p);
    logic [31:0] r;
    r = c;
    for (int i = 31; i >= 0; i--) r = (r[31] ^ d[i]) ? ({r[30:0], 1'b0} ^ p) : {r[30:0], 1'b0};
    return r;
  endfunction
  function automatic logic [31:0] ctl(input dcpu_mode_t m, input logic t);
    return {26'h0000000, t, 2'h0, m, 1'b1};
  endfunction
  task automatic chk(input string nm, input logic [32:0] e, input logic [32:0] g);
    cmp_count++;
    if (e !== g) begin
      failures++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic conclude;
    $display("comparisons %0d mismatches %0d", cmp_count, failures);
    if (failures == 0 && cmp_count > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  // one edge passes after release so back-to-back calls never drive psel twice per step
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= d;
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask
  task automatic rd(input logic [11:0] a, input logic [31:0] e, input logic err = 1'b0);
    expRd.push_back({err, e});
    apb(1'b0, a, 32'h00000000);
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic err = 1'b0);
    expRd.push_back({err, 32'h00000000});
    apb(1'b1, a, d);
  endtask
  task automatic drain;
    repeat (400) if (expDst.size() != 0) @(posedge clk);
    chk("dst backlog", 33'h000000000, 33'(expDst.size()));
  endtask
  task automatic irqChk(input logic e);
    repeat (2) @(posedge clk);
    chk("irq", {32'h00000000, e}, {32'h00000000, irq});
  endtask

  // ----------------------------------------------------------------------
  // clock, watchdog and result monitor
  // ----------------------------------------------------------------------
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  // the run needs well under a thousand cycles, so this leaves a wide margin
  initial begin
    repeat (20000) @(posedge clk);
    failures++;
    $display("ERROR watchdog expected finish seen timeout");
    conclude();
  end
  // oldest note is matched against each finished apb transfer and each word the destination takes
  always @(posedge clk) begin
    if (!sys_rst && psel && penable && pready === 1'b1)
      chk("apb", expRd.size() > 0 ? expRd.pop_front() : '1, {pslverr, prdata});
    if (!sys_rst && dstValid === 1'b1 && dstReady)
      chk("dst", expDst.size() > 0 ? expDst.pop_front() : '1, {dstRowEnd, dstData});
    if (!sys_rst && faultTrig === 1'b1) trigCount++;
  end

  // ----------------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------------
  initial begin
    {psel, penable, pwrite, paddr, pwdata} = '0;
    sys_rst = 1'b1;
    stall = 1'b0;
    dims = '{32'h00020003, 32'h00000000};
    void'($urandom(75016));
    repeat (20) @(posedge clk);
    sys_rst <= 1'b0;
    @(posedge clk);
    // reset values, a write-only read and an unmapped place
    rd(`DCPU_OFS_CTRL, `DCPU_CTRL_RST);
    rd(`DCPU_OFS_POLY, `DCPU_POLY_RST);
    rd(`DCPU_OFS_RESULT, `DCPU_SEED_RST);
    rd(`DCPU_OFS_STATUS, 32'h00000000);
    rd(`DCPU_OFS_CMD, 32'h00000000);
    rd(12'h030, 32'h00000000, 1'b1);
    wr(12'h030, 32'hffffffff, 1'b1);
    // scan with a user polynomial
    poly = $urandom() | 32'h00000001;
    wr(`DCPU_OFS_POLY, poly);
    rd(`DCPU_OFS_POLY, poly);
    wr(`DCPU_OFS_CTRL, ctl(DCPU_SCAN, 1'b1));
    wr(`DCPU_OFS_SEED, 32'hffffffff);
    crc = 32'hffffffff;
    for (int i = 0; i < 8; i++) begin
      w = $urandom();
      crc = crcStep(crc, w, poly);
      i_dcpu_dma_model.send(w);
    end
    rd(`DCPU_OFS_RESULT, crc);
    rd(`DCPU_OFS_WCOUNT, 32'h00000008);
    // mismatch masked, then enabled, then cleared; a match raises no fault
    wr(`DCPU_OFS_EXPECT, crc ^ 32'h00000001);
    wr(`DCPU_OFS_CMD, 32'h00000001);
    rd(`DCPU_OFS_STATUS, 32'h00000009);
    irqChk(1'b0);
    wr(`DCPU_OFS_INTEN, 32'h00000001);
    irqChk(1'b1);
    chk("trig", 33'h000000001, 33'(trigCount));
    wr(`DCPU_OFS_INTCLR, 32'h0000000f);
    irqChk(1'b0);
    // a second mismatch with the interrupt already enabled
    wr(`DCPU_OFS_CMD, 32'h00000001);
    irqChk(1'b1);
    wr(`DCPU_OFS_INTCLR, 32'h0000000f);
    wr(`DCPU_OFS_EXPECT, crc);
    wr(`DCPU_OFS_CMD, 32'h00000001);
    rd(`DCPU_OFS_STATUS, 32'h00000008);
    chk("trig", 33'h000000002, 33'(trigCount));
    wr(`DCPU_OFS_INTCLR, 32'h0000000f);
    // bit mirror, then byte mirror, each on one folded word
    for (int m = 0; m < 2; m++) begin
      wr(`DCPU_OFS_CTRL, ctl(DCPU_SCAN, 1'b0) | (32'h00000001 << (`DCPU_CTRL_BITMIR + m)));
      wr(`DCPU_OFS_SEED, 32'hffffffff);
      w = $urandom();
      for (int b = 0; b < 32; b++) mw[b] = (m == 0) ? w[31 - b] : w[b ^ 24];
      i_dcpu_dma_model.send(w);
      rd(`DCPU_OFS_RESULT, crcStep(32'hffffffff, mw, poly));
    end
    // transfer against a stalling destination
    stall <= 1'b1;
    wr(`DCPU_OFS_CTRL, ctl(DCPU_XFER, 1'b0));
    wr(`DCPU_OFS_SEED, 32'hffffffff);
    crc = 32'hffffffff;
    for (int i = 0; i < 6; i++) begin
      w = $urandom();
      crc = crcStep(crc, w, poly);
      expDst.push_back({1'b0, w});
      i_dcpu_dma_model.send(w);
    end
    drain();
    rd(`DCPU_OFS_RESULT, crc);
    // verify against the fill constant
    fv = $urandom();
    wr(`DCPU_OFS_FILLVAL, fv);
    wr(`DCPU_OFS_CTRL, ctl(DCPU_VERIFY, 1'b1));
    i_dcpu_dma_model.send(fv);
    rd(`DCPU_OFS_STATUS, 32'h00000000);
    i_dcpu_dma_model.send(fv ^ 32'h80000000);
    rd(`DCPU_OFS_STATUS, 32'h00000002);
    chk("trig", 33'h000000003, 33'(trigCount));
    wr(`DCPU_OFS_INTCLR, 32'h0000000f);
    // a 3x2 block, then a zero-sized one that counts as 1x1
    wr(`DCPU_OFS_CTRL, ctl(DCPU_FILL, 1'b0));
    wr(`DCPU_OFS_SEED, 32'hffffffff);
    crc = 32'hffffffff;
    foreach (dims[k]) begin
      nx = dims[k][15:0] == 16'h0000 ? 1 : int'(dims[k][15:0]);
      ny = dims[k][31:16] == 16'h0000 ? 1 : int'(dims[k][31:16]);
      for (int y = 0; y < ny; y++) begin
        for (int x = 0; x < nx; x++) begin
          expDst.push_back({(x == nx - 1), fv});
          crc = crcStep(crc, fv, poly);
        end
      end
      wr(`DCPU_OFS_FILLDIM, dims[k]);
      wr(`DCPU_OFS_CMD, 32'h00000002);
      drain();
      rd(`DCPU_OFS_STATUS, 32'h00000004);
    end
    rd(`DCPU_OFS_RESULT, crc);
    conclude();
  end
endmodule
